//--- core/regfield_pkg.sv
// package: offsets, field layouts, reset values and carriers of the register bank
package regfield_pkg;

    // ==========================================================
    // bus widths
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // register offsets, relative to the module base address
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_RAWSTAT = 12'h008;
    localparam logic [11:0] OFF_EVCLR = 12'h00C;
    localparam logic [11:0] OFF_START = 12'h010;
    localparam logic [11:0] OFF_ERRLATCH = 12'h014;
    localparam logic [11:0] OFF_WDATA = 12'h018;

    // ==========================================================
    // field positions, written as hi and lo with both ends included
    localparam int unsigned CTRL_HI = 7;
    localparam int unsigned CTRL_LO = 0;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned STATUS_HI = 8;
    localparam int unsigned STATUS_LO = 0;
    localparam int unsigned EVENT_HI = 7;
    localparam int unsigned EVENT_LO = 0;
    localparam int unsigned START_HI = 7;
    localparam int unsigned START_LO = 0;
    localparam int unsigned ERR_HI = 7;
    localparam int unsigned ERR_LO = 0;
    localparam int unsigned WDATA_HI = 15;
    localparam int unsigned WDATA_LO = 0;

    localparam int unsigned CTRL_W = CTRL_HI - CTRL_LO + 1;
    localparam int unsigned STATUS_W = STATUS_HI - STATUS_LO + 1;
    localparam int unsigned EVENT_W = EVENT_HI - EVENT_LO + 1;
    localparam int unsigned START_W = START_HI - START_LO + 1;
    localparam int unsigned ERR_W = ERR_HI - ERR_LO + 1;
    localparam int unsigned WDATA_W = WDATA_HI - WDATA_LO + 1;

    // ==========================================================
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [STATUS_W-1:0] STATUS_RST = 9'h000;
    localparam logic [EVENT_W-1:0] EVENT_RST = 8'h00;
    localparam logic [START_W-1:0] START_RST = 8'h00;
    localparam logic [ERR_W-1:0] ERR_RST = 8'h00;
    localparam logic [WDATA_W-1:0] WDATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] BASE_DEFAULT = 32'h0001_0000;

    // ==========================================================
    // access types of a field
    typedef enum logic [5:0] {
        ACC_RW  = 6'b000001,
        ACC_RO  = 6'b000010,
        ACC_RC  = 6'b000100,
        ACC_W1C = 6'b001000,
        ACC_W1S = 6'b010000,
        ACC_WO  = 6'b100000
    } access_t;

    // ==========================================================
    // request and answer carriers
    typedef struct packed {
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } acc_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [DATA_W-1:0] rdata;
    } acc_rsp_t;

endpackage : regfield_pkg

//--- core/access_field.sv
// one register field whose per-bit update follows its access type
`timescale 1ns/1ns
`default_nettype none

module access_field
    import regfield_pkg::*;
#(
    parameter access_t ACC = ACC_RW,
    parameter int unsigned WIDTH = 8,
    parameter logic [WIDTH-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH-1:0] hw_set,
    input wire logic [WIDTH-1:0] hw_clr,
    output logic [WIDTH-1:0] q
);

    // ==========================================================
    // per-bit next value
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        wire logic wr_one = wr_en & wdata[i];
        wire logic plain_d = wr_en ? wdata[i] : q[i];
        // hardware set wins over a read clear or a write-one clear in the same cycle
        wire logic rc_d = hw_set[i] | (q[i] & ~rd_en);
        wire logic w1c_d = hw_set[i] | (q[i] & ~wr_one);
        wire logic w1s_d = wr_one | (q[i] & ~hw_clr[i]);
        logic d;

        always_comb begin
            unique case (ACC)
                ACC_RW: d = plain_d;
                ACC_WO: d = plain_d;
                ACC_RO: d = hw_set[i];
                ACC_RC: d = rc_d;
                ACC_W1C: d = w1c_d;
                ACC_W1S: d = w1s_d;
                default: d = q[i];
            endcase
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                q[i] <= RST[i];
            end else begin
                q[i] <= d;
            end
        end
    end

endmodule : access_field

`default_nettype wire

//--- core/regfield_bank.sv
// register bank showing every field access type behind a simple access port
//
// Contract
// - a read-clear field returns its value, then hardware clears it after the read
// - writing one clears a write-one-clear bit; zero and other bits stay unchanged
// - writing back a read status value clears only the bits that read reported
// - a write-one-clear register without read access returns undefined data on read
// - a readable write-one-set field may be read; writing zero leaves bits unchanged
// - a write-only register acts on writes only; reads return nothing meaningful
// - register address is module base address plus the register offset
// - a field hi:lo covers every bit from lo to hi inclusive
`timescale 1ns/1ns
`default_nettype none

module regfield_bank
    import regfield_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BASE = BASE_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire acc_req_t acc_req,
    output acc_rsp_t acc_rsp,
    input wire logic [EVENT_W-1:0] hw_event,
    input wire logic [EVENT_W-1:0] hw_level,
    input wire logic [START_W-1:0] hw_done,
    input wire logic [ERR_W-1:0] hw_error,
    output logic [CTRL_W-1:0] ctrl_out,
    output logic [START_W-1:0] start_out,
    output logic [WDATA_W-1:0] wdata_out
);

    // ==========================================================
    // address decode
    wire logic [ADDR_W-1:0] addr_ctrl = BASE + ADDR_W'(OFF_CTRL);
    wire logic [ADDR_W-1:0] addr_status = BASE + ADDR_W'(OFF_STATUS);
    wire logic [ADDR_W-1:0] addr_rawstat = BASE + ADDR_W'(OFF_RAWSTAT);
    wire logic [ADDR_W-1:0] addr_evclr = BASE + ADDR_W'(OFF_EVCLR);
    wire logic [ADDR_W-1:0] addr_start = BASE + ADDR_W'(OFF_START);
    wire logic [ADDR_W-1:0] addr_errlatch = BASE + ADDR_W'(OFF_ERRLATCH);
    wire logic [ADDR_W-1:0] addr_wdata = BASE + ADDR_W'(OFF_WDATA);

    wire logic sel_ctrl = acc_req.addr == addr_ctrl;
    wire logic sel_status = acc_req.addr == addr_status;
    wire logic sel_rawstat = acc_req.addr == addr_rawstat;
    wire logic sel_evclr = acc_req.addr == addr_evclr;
    wire logic sel_start = acc_req.addr == addr_start;
    wire logic sel_errlatch = acc_req.addr == addr_errlatch;
    wire logic sel_wdata = acc_req.addr == addr_wdata;
    wire logic sel_any = sel_ctrl | sel_status | sel_rawstat | sel_evclr
                       | sel_start | sel_errlatch | sel_wdata;

    wire logic do_wr = acc_req.req & acc_req.we;
    wire logic do_rd = acc_req.req & ~acc_req.we;

    // ==========================================================
    // write data slices, each field taken hi:lo inclusive
    wire logic [CTRL_W-1:0] wd_ctrl = acc_req.wdata[CTRL_HI:CTRL_LO];
    wire logic [EVENT_W-1:0] wd_event = acc_req.wdata[EVENT_HI:EVENT_LO];
    wire logic [START_W-1:0] wd_start = acc_req.wdata[START_HI:START_LO];
    wire logic [WDATA_W-1:0] wd_wdata = acc_req.wdata[WDATA_HI:WDATA_LO];

    // ==========================================================
    // fields
    logic [CTRL_W-1:0] ctrl_q;
    logic [STATUS_W-1:0] status_q;
    logic [EVENT_W-1:0] rawstat_q;
    logic [START_W-1:0] start_q;
    logic [ERR_W-1:0] errlatch_q;
    logic [WDATA_W-1:0] wdata_q;

    wire logic ctrl_en = ctrl_q[CTRL_EN_BIT];
    // events only latch while the block is enabled
    wire logic [EVENT_W-1:0] event_gated = hw_event & {EVENT_W{ctrl_en}};
    wire logic [STATUS_W-1:0] status_live = {ctrl_en, hw_level};
    // both the readable status and the write-only clear register hit one store
    wire logic rawstat_wr = do_wr & (sel_rawstat | sel_evclr);

    access_field #(.ACC(ACC_RW), .WIDTH(CTRL_W), .RST(CTRL_RST)) u_ctrl (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(do_wr & sel_ctrl),
        .rd_en(1'b0),
        .wdata(wd_ctrl),
        .hw_set('0),
        .hw_clr('0),
        .q(ctrl_q)
    );

    // writes to the read-only status are dropped; software is expected to
    // write the reset value there anyway
    access_field #(.ACC(ACC_RO), .WIDTH(STATUS_W), .RST(STATUS_RST)) u_status (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(1'b0),
        .rd_en(1'b0),
        .wdata('0),
        .hw_set(status_live),
        .hw_clr('0),
        .q(status_q)
    );

    access_field #(.ACC(ACC_W1C), .WIDTH(EVENT_W), .RST(EVENT_RST)) u_rawstat (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(rawstat_wr),
        .rd_en(1'b0),
        .wdata(wd_event),
        .hw_set(event_gated),
        .hw_clr('0),
        .q(rawstat_q)
    );

    access_field #(.ACC(ACC_W1S), .WIDTH(START_W), .RST(START_RST)) u_start (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(do_wr & sel_start),
        .rd_en(1'b0),
        .wdata(wd_start),
        .hw_set('0),
        .hw_clr(hw_done),
        .q(start_q)
    );

    // the read that returns the value also clears it at the same edge;
    // an error arriving in that cycle survives
    access_field #(.ACC(ACC_RC), .WIDTH(ERR_W), .RST(ERR_RST)) u_errlatch (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(1'b0),
        .rd_en(do_rd & sel_errlatch),
        .wdata('0),
        .hw_set(hw_error),
        .hw_clr('0),
        .q(errlatch_q)
    );

    access_field #(.ACC(ACC_WO), .WIDTH(WDATA_W), .RST(WDATA_RST)) u_wdata (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(do_wr & sel_wdata),
        .rd_en(1'b0),
        .wdata(wd_wdata),
        .hw_set('0),
        .hw_clr('0),
        .q(wdata_q)
    );

    // ==========================================================
    // read data, reserved bits read as zero
    wire logic [DATA_W-1:0] rd_ctrl = DATA_W'(ctrl_q);
    wire logic [DATA_W-1:0] rd_status = DATA_W'(status_q);
    wire logic [DATA_W-1:0] rd_rawstat = DATA_W'(rawstat_q);
    wire logic [DATA_W-1:0] rd_start = DATA_W'(start_q);
    wire logic [DATA_W-1:0] rd_errlatch = DATA_W'(errlatch_q);
    // clear-only and write-only registers carry no readable state
    wire logic [DATA_W-1:0] rd_evclr = '0;
    wire logic [DATA_W-1:0] rd_wdata = '0;

    wire logic [DATA_W-1:0] rd_mux =
        ({DATA_W{sel_ctrl}} & rd_ctrl)
      | ({DATA_W{sel_status}} & rd_status)
      | ({DATA_W{sel_rawstat}} & rd_rawstat)
      | ({DATA_W{sel_evclr}} & rd_evclr)
      | ({DATA_W{sel_start}} & rd_start)
      | ({DATA_W{sel_errlatch}} & rd_errlatch)
      | ({DATA_W{sel_wdata}} & rd_wdata);

    // ==========================================================
    // answer: one cycle after the request, unmapped addresses flag an error
    acc_rsp_t rsp_d;
    acc_rsp_t rsp_q;

    assign rsp_d = '{
        ack: acc_req.req,
        err: acc_req.req & ~sel_any,
        rdata: do_rd ? rd_mux : '0
    };

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // ==========================================================
    // outputs
    // the copies lag their fields by one cycle so every output leaves a flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_out <= CTRL_RST;
        end else begin
            ctrl_out <= ctrl_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_out <= START_RST;
        end else begin
            start_out <= start_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdata_out <= WDATA_RST;
        end else begin
            wdata_out <= wdata_q;
        end
    end

    assign acc_rsp = rsp_q;

endmodule : regfield_bank

`default_nettype wire

//--- tb/regfield_bank_props.sv
// assertions on the access port of the register bank
`timescale 1ns/1ns
`default_nettype none

module regfield_bank_props
    import regfield_pkg::*;
#(
    parameter logic [ADDR_W-1:0] BASE = BASE_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire acc_req_t acc_req,
    input wire acc_rsp_t acc_rsp,
    input wire logic [ERR_W-1:0] hw_error,
    input wire logic [START_W-1:0] start_out
);
    // ====================
    // address decode
    wire logic [ADDR_W-1:0] off = acc_req.addr - BASE;
    wire logic mapped = (off[ADDR_W-1:5] == '0) && (off[1:0] == 2'h0) && (off[4:2] != 3'h7);
    wire logic rd = acc_req.req && !acc_req.we;
    wire logic wr = acc_req.req && acc_req.we;
    wire logic at_ctrl = off == ADDR_W'(OFF_CTRL);
    wire logic at_evclr = off == ADDR_W'(OFF_EVCLR);
    wire logic at_start = off == ADDR_W'(OFF_START);
    wire logic at_err = off == ADDR_W'(OFF_ERRLATCH);
    wire logic at_wdata = off == ADDR_W'(OFF_WDATA);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ====================
    // properties
    sequence s_err_rd_quiet;
        rd && at_err && hw_error == '0;
    endsequence
    sequence s_err_rd;
        rd && at_err;
    endsequence
    sequence s_err_gap;
        hw_error == '0;
    endsequence

    property p_ack_next; acc_req.req |=> acc_rsp.ack; endproperty
    property p_ack_idle; !acc_req.req |=> !acc_rsp.ack; endproperty
    property p_err_unmapped; acc_req.req && !mapped |=> acc_rsp.err && acc_rsp.rdata == '0; endproperty
    property p_ok_mapped; acc_req.req && mapped |=> !acc_rsp.err; endproperty
    property p_evclr_read; rd && at_evclr |=> acc_rsp.rdata == '0; endproperty
    property p_wdata_read; rd && at_wdata |=> acc_rsp.rdata == '0; endproperty
    property p_ctrl_width; rd && at_ctrl |=> acc_rsp.rdata[DATA_W-1:CTRL_HI+1] == '0; endproperty
    property p_rc_clear; s_err_rd_quiet ##1 s_err_gap ##1 s_err_rd |=> acc_rsp.rdata == '0; endproperty
    // software set wins over hw_done, so the set bits must show on start_out
    property p_w1s_out;
        wr && at_start |-> ##2 (start_out & $past(acc_req.wdata[START_W-1:0], 2))
            == $past(acc_req.wdata[START_W-1:0], 2);
    endproperty

    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
    a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access refused");
    a_evclr_read: assert property (p_evclr_read) else $error("clear-only reg read nonzero");
    a_wdata_read: assert property (p_wdata_read) else $error("write-only reg read nonzero");
    a_ctrl_width: assert property (p_ctrl_width) else $error("bits above field set");
    a_rc_clear: assert property (p_rc_clear) else $error("read-clear field kept");
    a_w1s_out: assert property (p_w1s_out) else $error("set bits missing on output");
endmodule : regfield_bank_props

bind regfield_bank regfield_bank_props #(.BASE(BASE)) regfield_bank_props_inst (.clk(clk),
    .rst_n(rst_n), .acc_req(acc_req), .acc_rsp(acc_rsp), .hw_error(hw_error),
    .start_out(start_out));

`default_nettype wire

//--- tb/regfield_bank_tb_top.sv
// self-checking bench of the register bank
`timescale 1ns/1ns
`default_nettype none

module regfield_bank_tb_top
    import regfield_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    acc_req_t req = '0;
    acc_rsp_t rsp;
    logic [7:0] ev = 8'h00, lvl = 8'h00, done = 8'h00, herr = 8'h00;
    logic [7:0] ctrl_o, start_o;
    logic [15:0] wd_o;
    logic [31:0] rd;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    regfield_bank regfield_bank_inst (.clk(clk), .rst_n(rst_n), .acc_req(req), .acc_rsp(rsp),
        .hw_event(ev), .hw_level(lvl), .hw_done(done), .hw_error(herr), .ctrl_out(ctrl_o),
        .start_out(start_o), .wdata_out(wd_o));

    initial forever #50 clk = ~clk;

    // ====================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one access; the answer is looked at in its single ack cycle
    task automatic acc(input logic we, input logic [11:0] off, input logic [31:0] wd,
        input logic exp_err);
        @(posedge clk);
        req <= '{req: 1'b1, we: we, addr: BASE_DEFAULT + 32'(off), wdata: wd};
        @(posedge clk);
        req.req <= 1'b0;
        #1;
        check("ack", {31'h0, rsp.ack}, 32'h1);
        check("err", {31'h0, rsp.err}, {31'h0, exp_err});
        if (we) check("wr rdata", rsp.rdata, 32'h0);
        rd = rsp.rdata;
    endtask : acc

    task automatic rchk(input string what, input logic [11:0] off, input logic [31:0] exp);
        acc(1'b0, off, 32'h0, 1'b0);
        check(what, rd, exp);
    endtask : rchk

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    // ====================
    // scenarios
    task automatic t_map();
        rchk("ctrl rst", OFF_CTRL, 32'h0);
        acc(1'b0, 12'h01C, 32'h0, 1'b1);
        acc(1'b1, 12'h002, 32'hFF, 1'b1);
        rchk("ctrl kept", OFF_CTRL, 32'h0);
    endtask : t_map

    task automatic t_read_clear();
        @(posedge clk);
        herr <= 8'hA5;
        @(posedge clk);
        herr <= 8'h00;
        rchk("err latch", OFF_ERRLATCH, 32'hA5);
        rchk("err clear", OFF_ERRLATCH, 32'h0);
    endtask : t_read_clear

    task automatic t_w1c();
        // events must not latch while the block is disabled
        @(posedge clk);
        ev <= 8'hFF;
        @(posedge clk);
        ev <= 8'h00;
        rchk("raw gated", OFF_RAWSTAT, 32'h0);
        acc(1'b1, OFF_CTRL, 32'h1, 1'b0);
        @(posedge clk);
        ev <= 8'hFF;
        @(posedge clk);
        ev <= 8'h00;
        rchk("raw all", OFF_RAWSTAT, 32'hFF);
        acc(1'b1, OFF_RAWSTAT, 32'h0F, 1'b0);
        rchk("raw w1c", OFF_RAWSTAT, 32'hF0);
        @(posedge clk);
        ev <= 8'h01;
        @(posedge clk);
        ev <= 8'h00;
        acc(1'b1, OFF_RAWSTAT, 32'hF0, 1'b0);
        rchk("raw new", OFF_RAWSTAT, 32'h01);
        acc(1'b1, OFF_EVCLR, 32'h01, 1'b0);
        rchk("raw evclr", OFF_RAWSTAT, 32'h0);
        rchk("evclr rd", OFF_EVCLR, 32'h0);
    endtask : t_w1c

    task automatic t_w1s();
        acc(1'b1, OFF_START, 32'h81, 1'b0);
        acc(1'b1, OFF_START, 32'h02, 1'b0);
        acc(1'b1, OFF_START, 32'h00, 1'b0);
        rchk("start set", OFF_START, 32'h83);
        check("start out", {24'h0, start_o}, 32'h83);
        @(posedge clk);
        done <= 8'h01;
        @(posedge clk);
        done <= 8'h00;
        rchk("start done", OFF_START, 32'h82);
    endtask : t_w1s

    task automatic t_wo_width();
        acc(1'b1, OFF_WDATA, 32'h1234_BEEF, 1'b0);
        rchk("wdata rd", OFF_WDATA, 32'h0);
        check("wdata out", {16'h0, wd_o}, 32'h0000_BEEF);
        acc(1'b1, OFF_CTRL, 32'hFFFF_FFFF, 1'b0);
        rchk("ctrl width", OFF_CTRL, 32'hFF);
        check("ctrl out", {24'h0, ctrl_o}, 32'hFF);
        @(posedge clk);
        lvl <= 8'h3C;
        acc(1'b1, OFF_STATUS, 32'h0, 1'b0);
        rchk("status", OFF_STATUS, 32'h13C);
        // read-modify-write keeps the reserved bits as read
        rchk("ctrl again", OFF_CTRL, 32'hFF);
        acc(1'b1, OFF_CTRL, rd & 32'hFFFF_FFFE, 1'b0);
        rchk("ctrl rmw", OFF_CTRL, 32'hFE);
        rchk("status off", OFF_STATUS, 32'h03C);
    endtask : t_wo_width

    // ====================
    // main sequence and hang guard
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_map();
        t_read_clear();
        t_w1c();
        t_w1s();
        t_wo_width();
        end_of_test();
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_of_test();
        end
    end
endmodule : regfield_bank_tb_top

`default_nettype wire
